// ---- src/sifwd_pkg.sv ----
// constants and types for the shortcut ingress forwarding block
package sifwd_pkg;
	typedef enum logic [1:0] {SIFWD_RT_LANE, SIFWD_RT_SC, SIFWD_RT_DROP} sifwd_route_t;
	typedef enum logic [1:0] {SIFWD_ENC_NULL, SIFWD_ENC_LLC, SIFWD_ENC_TAG} sifwd_encap_t;
	typedef enum logic [1:0] {SIFWD_ICMP_TIME_EXC, SIFWD_ICMP_PARAM} sifwd_icmp_t;
	// header byte offsets inside the datagram
	localparam logic [15:0] SIFWD_IP_TTL_OFS = 16'h0008;
	localparam logic [15:0] SIFWD_IP_CSUM_OFS = 16'h000A;
	localparam logic [15:0] SIFWD_IPX_HOP_OFS = 16'h0004;
	localparam logic [15:0] SIFWD_IPX_CSUM_OFS = 16'h0000;
	// encapsulation prefix bytes
	localparam logic [7:0] SIFWD_LLC_DSAP = 8'hAA;
	localparam logic [7:0] SIFWD_LLC_CTRL = 8'h03;
	localparam logic [7:0] SIFWD_OUI_BYTE = 8'h00;
	localparam logic [15:0] SIFWD_ETYPE_IPX = 16'h8137;
	localparam logic [15:0] SIFWD_ETYPE_IP = 16'h0800;
	localparam logic [15:0] SIFWD_ETYPE_TAG = 16'h884C;
	localparam logic [3:0] SIFWD_PFX_LEN_LLC = 4'h8;
	localparam logic [3:0] SIFWD_PFX_LEN_TAG = 4'hC;
	// payload ceilings per encapsulation
	localparam logic [15:0] SIFWD_MAX_LLC = 16'hFFF7;
	localparam logic [15:0] SIFWD_MAX_TAG = 16'hFFF3;
	localparam logic [15:0] SIFWD_MAX_NULL = 16'hFFFF;
	// reset values and the minimum TTL decrement
	localparam logic [15:0] SIFWD_IDX_RST = 16'h0000;
	localparam logic [3:0] SIFWD_PFX_RST = 4'h0;
	localparam logic [7:0] SIFWD_TTL_DEC_MIN = 8'h01;
endpackage

// ---- src/sifwd_skid.sv ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sifwd_skid #(
	parameter int W = 10
) (
	input wire logic i_mclk, // clock
	input wire logic i_rst, // async reset, high
	input wire logic i_ce, // clock enable
	input wire logic i_valid, // write side valid
	output logic o_ready, // write side ready
	input wire logic [W-1:0] i_data, // write side data
	output logic o_valid, // read side valid
	input wire logic i_ready, // read side ready
	output logic [W-1:0] o_data // read side data
);
	logic [W-1:0] mem_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	wire logic wr_en = i_ce && i_valid && o_ready;
	wire logic rd_en = i_ce && o_valid && i_ready;

	if (W < 1)
	begin : g_chk
		$error("sifwd_skid: width must be positive");
	end

	assign o_ready = cnt_reg != 2'h2;
	assign o_valid = cnt_reg != 2'h0;
	assign o_data = mem_reg[rd_ptr_reg];
	assign cnt_next = cnt_reg + {1'b0, wr_en} - {1'b0, rd_en};

	always_ff @(posedge i_mclk)
	begin
		if (wr_en)
			mem_reg[wr_ptr_reg] <= i_data;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg ^ wr_en;
			rd_ptr_reg <= rd_ptr_reg ^ rd_en;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ---- src/sifwd_top.sv ----
// ingress shortcut forwarding: path decision, header rewrite, encapsulation
//
// Notes on behaviour
// R01 - IP option not handled: packet goes unchanged on the LAN path.
// R02 - options allowed on shortcut only when the option is fully supported.
// R03 - LAN path never touches the TTL.
// R04 - shortcut path lowers TTL by a configured amount, at least one.
// R05 - TTL at or below decrement: LAN unchanged, or drop with Time Exceeded.
// R06 - any IP header change gets a fixed-up header checksum.
// R07 - forwarding error: LAN unchanged, or drop with the matching ICMP error.
// R08 - shortcut MTU below inbound MTU: shortcut unused, no split by size.
// R09 - egress side owes no TTL decrement; this ingress block fragments nothing.
// R10 - IPX shortcut encapsulation is tagged, LLC/SNAP routed, or null.
// R11 - LLC/SNAP prefix AA AA 03 00 00 00 81 37, payload up to 65527.
// R12 - tagged prefix AA AA 03 00 00 00 88 4C plus tag, payload up to 65523.
// R13 - hop count extension from the route server bounds the hop counter.
// R14 - IPX hop counter is incremented by one on the shortcut.
// R15 - packets at hop limit are dropped or passed unchanged.
// R16 - IPX checksum is left alone when the hop counter changes.
// R17 - IPX shortcut only when hop counter below extension value, else LAN or drop.
// R18 - IPX with source network zero goes unchanged on the LAN path.
// R19 - IPX is never fragmented.
// R20 - exactly one output per packet; LAN copy is byte-identical.
`timescale 1ns/1ps
module sifwd_top (
	input wire logic i_mclk, // 125 MHz clock
	input wire logic i_rst, // async reset, high
	input wire logic i_ce, // clock enable, freezes state
	input wire logic i_valid, // input byte valid
	output logic o_in_ready, // input byte taken
	input wire logic i_sop, // first byte of packet
	input wire logic i_eop, // last byte of packet
	input wire logic [7:0] i_data, // packet byte
	input wire logic i_is_ipx, // packet is IPX, else IP
	input wire logic [15:0] i_pkt_len, // datagram length in octets
	input wire logic [7:0] i_ip_ttl, // IP ttl field
	input wire logic [7:0] i_ip_proto, // IP protocol field
	input wire logic [15:0] i_ip_csum, // IP header checksum
	input wire logic i_ip_opts, // IP options present
	input wire logic i_ip_hdr_bad, // IP header parameter problem
	input wire logic [7:0] i_ipx_hops, // IPX hop counter
	input wire logic i_ipx_src_net_zero, // IPX source network is zero
	input wire logic i_sc_hit, // resolved shortcut exists
	input wire logic i_sc_mtu_small, // shortcut MTU below inbound MTU
	input wire logic i_opt_ok, // all present IP options supported
	input wire logic [7:0] i_ttl_dec, // configured TTL decrement
	input wire logic [7:0] i_hop_ext, // resolved hop count extension
	input wire sifwd_pkg::sifwd_encap_t i_encap, // shortcut encapsulation
	input wire logic [31:0] i_tag, // tag word for tagged encapsulation
	input wire logic i_drop_policy, // drop instead of LAN, with ICMP for IP only
	output logic o_sc_valid, // shortcut byte valid
	input wire logic i_sc_ready, // shortcut sink ready
	output logic o_sc_sop, // shortcut first byte
	output logic o_sc_eop, // shortcut last byte
	output logic [7:0] o_sc_data, // shortcut byte
	output logic o_lan_valid, // LAN byte valid
	input wire logic i_lan_ready, // LAN sink ready
	output logic o_lan_sop, // LAN first byte
	output logic o_lan_eop, // LAN last byte
	output logic [7:0] o_lan_data, // LAN byte
	output logic o_icmp_valid, // ICMP request pulse
	output sifwd_pkg::sifwd_icmp_t o_icmp_type, // ICMP error kind
	output logic o_drop // packet dropped pulse
);
	import sifwd_pkg::*;

	typedef enum logic [1:0] {SIFWD_ST_IDLE, SIFWD_ST_PFX, SIFWD_ST_BODY} sifwd_state_t;

	function automatic logic [15:0] csum_adj(logic [15:0] hc, logic [15:0] m, logic [15:0] mn);
		logic [17:0] s;
		s = {2'h0, ~hc} + {2'h0, ~m} + {2'h0, mn};
		s = {2'h0, s[15:0]} + {16'h0, s[17:16]};
		s = {2'h0, s[15:0]} + {16'h0, s[17:16]};
		return ~s[15:0];
	endfunction

	function automatic logic [7:0] pfx_byte(sifwd_encap_t enc, logic ipx, logic [3:0] k,
		logic [31:0] tag);
		logic [15:0] et;
		et = (enc == SIFWD_ENC_TAG) ? SIFWD_ETYPE_TAG : (ipx ? SIFWD_ETYPE_IPX : SIFWD_ETYPE_IP);
		case (k)
			4'h0, 4'h1: return SIFWD_LLC_DSAP;
			4'h2: return SIFWD_LLC_CTRL;
			4'h6: return et[15:8];
			4'h7: return et[7:0];
			4'h8: return tag[31:24];
			4'h9: return tag[23:16];
			4'hA: return tag[15:8];
			4'hB: return tag[7:0];
			default: return SIFWD_OUI_BYTE;
		endcase
	endfunction

	sifwd_state_t state_reg;
	sifwd_state_t state_next;
	sifwd_route_t route_reg;
	sifwd_encap_t encap_reg;
	logic ipx_reg;
	logic [7:0] ttl_reg;
	logic [15:0] csum_reg;
	logic [7:0] hops_reg;
	logic [31:0] tag_reg;
	logic [3:0] pfx_reg;
	logic [15:0] idx_reg;
	logic icmp_valid_reg;
	sifwd_icmp_t icmp_type_reg;
	logic drop_reg;

	// decision, taken from the descriptor at the first byte
	wire logic [7:0] dec_eff = (i_ttl_dec < SIFWD_TTL_DEC_MIN) ? SIFWD_TTL_DEC_MIN : i_ttl_dec; // R04
	wire logic [7:0] ttl_new = i_ip_ttl - dec_eff; // R04
	wire logic [15:0] csum_new = csum_adj(i_ip_csum, {i_ip_ttl, i_ip_proto},
		{ttl_new, i_ip_proto}); // R06
	wire logic [15:0] len_max = (i_encap == SIFWD_ENC_LLC) ? SIFWD_MAX_LLC :
		(i_encap == SIFWD_ENC_TAG) ? SIFWD_MAX_TAG : SIFWD_MAX_NULL; // R11 R12
	wire logic len_big = i_pkt_len > len_max; // R11 R12
	wire logic ttl_low = i_ip_ttl <= dec_eff; // R05
	wire logic hop_over = i_ipx_hops >= i_hop_ext; // R13 R15 R17
	wire logic opt_block = i_ip_opts && !i_opt_ok; // R01 R02
	// shortcut MTU too small means no shortcut at all, never a per-size split
	wire logic no_sc = !i_sc_hit || i_sc_mtu_small || len_big ||
		(i_is_ipx ? i_ipx_src_net_zero : opt_block); // R08 R09 R18 R19
	wire logic fwd_err = i_is_ipx ? hop_over : (ttl_low || i_ip_hdr_bad); // R05 R07 R17
	wire sifwd_route_t route_dec = no_sc ? SIFWD_RT_LANE :
		fwd_err ? (i_drop_policy ? SIFWD_RT_DROP : SIFWD_RT_LANE) : SIFWD_RT_SC; // R15 R20
	wire logic start = i_ce && (state_reg == SIFWD_ST_IDLE) && i_valid && i_sop;
	wire logic [3:0] pfx_len = (i_encap == SIFWD_ENC_LLC) ? SIFWD_PFX_LEN_LLC :
		(i_encap == SIFWD_ENC_TAG) ? SIFWD_PFX_LEN_TAG : SIFWD_PFX_RST; // R10
	wire logic [3:0] pfx_last = (encap_reg == SIFWD_ENC_TAG) ? SIFWD_PFX_LEN_TAG - 4'h1 :
		SIFWD_PFX_LEN_LLC - 4'h1;

	// byte path
	wire logic in_body = state_reg == SIFWD_ST_BODY;
	wire logic in_pfx = state_reg == SIFWD_ST_PFX;
	wire logic sc_body = in_body && (route_reg == SIFWD_RT_SC);
	wire logic lan_body = in_body && (route_reg == SIFWD_RT_LANE);
	wire logic sc_in_ready;
	wire logic lan_in_ready;
	wire logic sc_in_valid = in_pfx || (sc_body && i_valid); // R20
	wire logic lan_in_valid = lan_body && i_valid; // R20
	wire logic ip_ttl_byte = !ipx_reg && (idx_reg == SIFWD_IP_TTL_OFS);
	wire logic ip_csum_hi = !ipx_reg && (idx_reg == SIFWD_IP_CSUM_OFS);
	wire logic ip_csum_lo = !ipx_reg && (idx_reg == SIFWD_IP_CSUM_OFS + 16'h0001);
	wire logic ipx_hop_byte = ipx_reg && (idx_reg == SIFWD_IPX_HOP_OFS);
	// the IPX checksum bytes pass untouched: the hop counter lies outside its cover
	wire logic [7:0] body_byte = ip_ttl_byte ? ttl_reg : // R04
		ip_csum_hi ? csum_reg[15:8] : // R06
		ip_csum_lo ? csum_reg[7:0] : // R06
		ipx_hop_byte ? hops_reg : i_data; // R14 R16
	wire logic [7:0] sc_byte = in_pfx ? pfx_byte(encap_reg, ipx_reg, pfx_reg, tag_reg) :
		body_byte; // R10 R11 R12
	wire logic sc_sop = in_pfx ? (pfx_reg == SIFWD_PFX_RST) :
		(i_sop && (encap_reg == SIFWD_ENC_NULL));
	wire logic sc_eop = !in_pfx && i_eop;
	wire logic idle_skip = (state_reg == SIFWD_ST_IDLE) && i_valid && !i_sop;
	wire logic drop_body = in_body && (route_reg == SIFWD_RT_DROP);
	wire logic take = sc_body ? sc_in_ready : lan_body ? lan_in_ready : drop_body;
	wire logic beat = i_ce && in_body && i_valid && take;
	wire logic pfx_step = i_ce && in_pfx && sc_in_ready;

	assign o_in_ready = (in_body && take) || idle_skip;
	assign o_icmp_valid = icmp_valid_reg;
	assign o_icmp_type = icmp_type_reg;
	assign o_drop = drop_reg;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			SIFWD_ST_IDLE:
				if (i_valid && i_sop)
					state_next = ((route_dec == SIFWD_RT_SC) && (pfx_len != SIFWD_PFX_RST)) ?
						SIFWD_ST_PFX : SIFWD_ST_BODY;
			SIFWD_ST_PFX:
				if (sc_in_ready && (pfx_reg == pfx_last))
					state_next = SIFWD_ST_BODY;
			SIFWD_ST_BODY:
				if (i_valid && take && i_eop)
					state_next = SIFWD_ST_IDLE;
			default:
				state_next = SIFWD_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_reg <= SIFWD_ST_IDLE;
			route_reg <= SIFWD_RT_LANE;
			encap_reg <= SIFWD_ENC_NULL;
			ipx_reg <= 1'b0;
			ttl_reg <= 8'h00;
			csum_reg <= 16'h0000;
			hops_reg <= 8'h00;
			tag_reg <= 32'h00000000;
			pfx_reg <= SIFWD_PFX_RST;
			idx_reg <= SIFWD_IDX_RST;
		end
		else if (i_ce)
		begin
			state_reg <= state_next;
			if (start)
			begin
				route_reg <= route_dec;
				encap_reg <= i_encap;
				ipx_reg <= i_is_ipx;
				ttl_reg <= ttl_new;
				csum_reg <= csum_new;
				hops_reg <= i_ipx_hops + 8'h01; // R14
				tag_reg <= i_tag;
				pfx_reg <= SIFWD_PFX_RST;
				idx_reg <= SIFWD_IDX_RST;
			end
			if (pfx_step)
				pfx_reg <= pfx_reg + 4'h1;
			if (beat)
				idx_reg <= idx_reg + 16'h0001;
		end
	end

	// ICMP request and drop marker, one cycle each
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			icmp_valid_reg <= 1'b0;
			icmp_type_reg <= SIFWD_ICMP_TIME_EXC;
			drop_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			drop_reg <= start && (route_dec == SIFWD_RT_DROP); // R15
			icmp_valid_reg <= start && (route_dec == SIFWD_RT_DROP) && !i_is_ipx; // R05 R07
			if (start)
				icmp_type_reg <= ttl_low ? SIFWD_ICMP_TIME_EXC : SIFWD_ICMP_PARAM; // R07
		end
	end

	sifwd_skid #(.W(10)) u_sc_buf (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_valid(sc_in_valid),
		.o_ready(sc_in_ready),
		.i_data({sc_sop, sc_eop, sc_byte}),
		.o_valid(o_sc_valid),
		.i_ready(i_sc_ready),
		.o_data({o_sc_sop, o_sc_eop, o_sc_data})
	);

	sifwd_skid #(.W(10)) u_lan_buf (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_valid(lan_in_valid),
		.o_ready(lan_in_ready),
		.i_data({i_sop, i_eop, i_data}), // R03 R20
		.o_valid(o_lan_valid),
		.i_ready(i_lan_ready),
		.o_data({o_lan_sop, o_lan_eop, o_lan_data})
	);

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	wire logic acc_sc = i_ce && sc_body && i_valid && sc_in_ready;
	wire logic acc_lan = i_ce && lan_body && i_valid && lan_in_ready;

	property p_opt_lane;
		start && !i_is_ipx && opt_block |=> route_reg == SIFWD_RT_LANE;
	endproperty
	a_opt_lane: assert property (p_opt_lane) else $error("unsupported option not on LAN"); // R01

	property p_lane_same;
		acc_lan && !o_lan_valid |=> o_lan_valid && o_lan_data == $past(i_data);
	endproperty
	a_lane_same: assert property (p_lane_same) else $error("LAN copy altered"); // R20

	property p_lane_ttl;
		acc_lan && !ipx_reg && idx_reg == SIFWD_IP_TTL_OFS |=> o_lan_valid;
	endproperty
	a_lane_ttl: assert property (p_lane_ttl) else $error("LAN byte lost"); // R03

	property p_ttl_dec;
		acc_sc && ip_ttl_byte |-> sc_byte == ttl_reg && ttl_reg < i_data;
	endproperty
	a_ttl_dec: assert property (p_ttl_dec) else $error("TTL not lowered"); // R04

	property p_ttl_low;
		start && !i_is_ipx && ttl_low |=> route_reg != SIFWD_RT_SC;
	endproperty
	a_ttl_low: assert property (p_ttl_low) else $error("low TTL sent on shortcut"); // R05

	property p_csum;
		acc_sc && ip_csum_hi |-> sc_byte == csum_reg[15:8];
	endproperty
	a_csum: assert property (p_csum) else $error("checksum not rewritten"); // R06

	property p_icmp;
		start && route_dec == SIFWD_RT_DROP && !i_is_ipx |=> o_icmp_valid && o_drop ##1 !o_icmp_valid;
	endproperty
	a_icmp: assert property (p_icmp) else $error("ICMP pulse wrong"); // R07

	property p_mtu;
		start && i_sc_mtu_small |=> route_reg == SIFWD_RT_LANE;
	endproperty
	a_mtu: assert property (p_mtu) else $error("shortcut used with small MTU"); // R08

	property p_llc;
		i_ce && in_pfx && encap_reg == SIFWD_ENC_LLC && ipx_reg && pfx_reg == 4'h6
			|-> sc_byte == 8'h81;
	endproperty
	a_llc: assert property (p_llc) else $error("LLC ethertype wrong"); // R11

	property p_hops;
		acc_sc && ipx_hop_byte |-> sc_byte == i_data + 8'h01;
	endproperty
	a_hops: assert property (p_hops) else $error("hop counter not incremented"); // R14

	property p_ipx_csum;
		acc_sc && ipx_reg && idx_reg[15:1] == SIFWD_IPX_CSUM_OFS[15:1] |-> sc_byte == i_data;
	endproperty
	a_ipx_csum: assert property (p_ipx_csum) else $error("IPX checksum altered"); // R16

	property p_hop_lim;
		start && i_is_ipx && hop_over |=> route_reg != SIFWD_RT_SC;
	endproperty
	a_hop_lim: assert property (p_hop_lim) else $error("hop limit ignored"); // R17

	property p_net0;
		start && i_is_ipx && i_ipx_src_net_zero |=> route_reg == SIFWD_RT_LANE;
	endproperty
	a_net0: assert property (p_net0) else $error("zero network on shortcut"); // R18

	c_sc_pkt: cover property (acc_sc && i_eop);
	c_lan_pkt: cover property (acc_lan && i_eop);
	c_drop: cover property (o_drop);
endmodule

// ---- verif/sifwd_sink.sv ----
// far-side byte sink for one output stream, with optional slow acceptance
`timescale 1ns/1ps
module sifwd_sink (
	input wire logic i_mclk, // clock
	input wire logic i_rst, // async reset, high
	input wire logic i_ce, // clock enable of the block
	input wire logic i_stall, // accept only one cycle in four
	input wire logic i_valid, // byte valid
	input wire logic i_sop, // first byte
	input wire logic i_eop, // last byte
	input wire logic [7:0] i_data, // byte
	output logic o_ready // sink ready
);
	logic [1:0] ph_reg;
	logic [9:0] q[$];
	// every accepted byte kept with its framing bits
	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ph_reg <= 2'h0;
			o_ready <= 1'b0;
		end
		else
		begin
			ph_reg <= ph_reg + 2'h1;
			o_ready <= !i_stall || ph_reg == 2'h3;
			if (i_ce && i_valid && o_ready)
				q.push_back({i_sop, i_eop, i_data});
		end
	end
endmodule

// ---- verif/sifwd_top_bench.sv ----
// self-checking bench for the shortcut ingress forwarding block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module sifwd_top_bench;
	import sifwd_pkg::*;
	logic clk = 0, rst = 1, valid = 0, sop = 0, eop = 0, is_ipx = 0, opts = 0, bad = 0;
	logic net0 = 0, hit = 1, mtu_small = 0, opt_ok = 0, pol = 0, stall = 0, ce = 1, ce_gap = 0;
	logic [7:0] data = 0, ttl = 8'h40, proto = 8'h06, hops = 0, dec = 8'h01, hop_ext = 8'h10;
	logic [15:0] csum = 16'h1234, len = 16'h0010;
	logic [31:0] tag = 32'hA1B2C3D4;
	sifwd_encap_t encap = SIFWD_ENC_NULL;
	wire in_ready, sc_valid, sc_ready, sc_sop, sc_eop, lan_valid, lan_ready, lan_sop, lan_eop;
	wire icmp_valid, drop;
	wire [7:0] sc_data, lan_data;
	sifwd_icmp_t icmp_type;
	int errors = 0, compares = 0, cycles = 0, n_drop = 0, n_icmp = 0;
	logic [7:0] pkt[16];

	sifwd_top u_dut (.i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_valid(valid),
		.o_in_ready(in_ready), .i_sop(sop), .i_eop(eop), .i_data(data), .i_is_ipx(is_ipx),
		.i_pkt_len(len), .i_ip_ttl(ttl), .i_ip_proto(proto), .i_ip_csum(csum), .i_ip_opts(opts),
		.i_ip_hdr_bad(bad), .i_ipx_hops(hops), .i_ipx_src_net_zero(net0), .i_sc_hit(hit),
		.i_sc_mtu_small(mtu_small), .i_opt_ok(opt_ok), .i_ttl_dec(dec), .i_hop_ext(hop_ext),
		.i_encap(encap), .i_tag(tag), .i_drop_policy(pol), .o_sc_valid(sc_valid),
		.i_sc_ready(sc_ready), .o_sc_sop(sc_sop), .o_sc_eop(sc_eop), .o_sc_data(sc_data),
		.o_lan_valid(lan_valid), .i_lan_ready(lan_ready), .o_lan_sop(lan_sop),
		.o_lan_eop(lan_eop), .o_lan_data(lan_data), .o_icmp_valid(icmp_valid),
		.o_icmp_type(icmp_type), .o_drop(drop));
	sifwd_sink u_sc (.i_mclk(clk), .i_rst(rst), .i_stall(stall), .i_valid(sc_valid),
		.i_ce(ce), .i_sop(sc_sop), .i_eop(sc_eop), .i_data(sc_data), .o_ready(sc_ready));
	sifwd_sink u_lan (.i_mclk(clk), .i_rst(rst), .i_stall(stall), .i_valid(lan_valid),
		.i_ce(ce), .i_sop(lan_sop), .i_eop(lan_eop), .i_data(lan_data), .o_ready(lan_ready));

	always #4 clk = ~clk;

	task automatic complete_run;
		if (errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		ce <= !ce_gap || cycles % 3 != 0;
		if (drop === 1'b1)
			n_drop++;
		if (icmp_valid === 1'b1)
			n_icmp++;
		if (cycles == 20000)
		begin
			errors++;
			complete_run();
		end
	end

	// one's-complement header checksum fix-up for one changed word
	function automatic logic [15:0] fix(logic [15:0] hc, logic [15:0] m, logic [15:0] mn);
		logic [16:0] s;
		s = {1'b0, ~hc} + {1'b0, ~m};
		s = s[15:0] + s[16];
		s = {1'b0, s[15:0]} + {1'b0, mn};
		s = s[15:0] + s[16];
		return ~s[15:0];
	endfunction

	// rt: 0 LAN path, 1 shortcut, 2 dropped
	task automatic run(input int rt);
		logic [9:0] e[$];
		logic [9:0] g[$];
		logic [95:0] pre;
		logic [7:0] nt;
		int k, np, d0, i0;
		logic tk;
		@(posedge clk);
		for (k = 0; k < 16; k++)
			pkt[k] = 8'h20 + k[7:0];
		if (is_ipx)
			pkt[4] = hops;
		else
			{pkt[8], pkt[9], pkt[10], pkt[11]} = {ttl, proto, csum};
		u_sc.q.delete();
		u_lan.q.delete();
		d0 = n_drop;
		i0 = n_icmp;
		np = (rt != 1 || encap == SIFWD_ENC_NULL) ? 0 : (encap == SIFWD_ENC_TAG) ? 12 : 8;
		pre = {48'hAAAA03000000, is_ipx ? 16'h8137 : 16'h0800, 32'h0};
		if (encap == SIFWD_ENC_TAG)
			pre = {48'hAAAA03000000, 16'h884C, tag};
		for (k = 0; k < np; k++)
			e.push_back({2'b00, pre[95 - 8 * k -: 8]});
		for (k = 0; k < 16; k++)
			e.push_back({2'b00, pkt[k]});
		if (rt == 1 && is_ipx)
			e[np + 4][7:0] = hops + 8'h01;
		nt = ttl - ((dec == 8'h00) ? 8'h01 : dec);
		if (rt == 1 && !is_ipx)
			{e[np + 8][7:0], e[np + 10][7:0], e[np + 11][7:0]} = {nt, fix(csum, {ttl, proto},
				{nt, proto})};
		e[0][9] = 1'b1;
		e[e.size() - 1][8] = 1'b1;
		if (rt == 2)
			e.delete();
		valid <= 1'b1;
		sop <= 1'b1;
		data <= pkt[0];
		k = 0;
		while (k < 16)
		begin
			@(negedge clk);
			tk = in_ready && ce;
			@(posedge clk);
			if (tk)
			begin
				k++;
				sop <= 1'b0;
				eop <= k == 15;
				data <= pkt[k % 16];
				valid <= k < 16;
			end
		end
		for (k = 0; k < 300 && u_sc.q.size() + u_lan.q.size() < e.size(); k++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		g = (rt == 1) ? u_sc.q : u_lan.q;
		`CHK(g.size(), e.size())
		foreach (e[j])
			if (j < g.size())
				`CHK(g[j], e[j])
		`CHK(((rt == 1) ? u_lan.q.size() : u_sc.q.size()), 0)
		`CHK(n_drop - d0, int'(rt == 2))
		`CHK(n_icmp - i0, int'(rt == 2 && !is_ipx))
	endtask

	task automatic t_ip_sc;
		for (int i = 0; i < 3; i++)
		begin
			encap <= sifwd_encap_t'(i);
			dec <= (i == 2) ? 8'h03 : 8'h01;
			run(1);
		end
		dec <= 8'h00;
		run(1);
	endtask

	task automatic t_ip_ttl;
		dec <= 8'h03;
		ttl <= 8'h03;
		run(0);
		pol <= 1'b1;
		run(2);
		`CHK(icmp_type, SIFWD_ICMP_TIME_EXC)
		ttl <= 8'h04;
		run(1);
		pol <= 1'b0;
	endtask

	task automatic t_ip_err;
		bad <= 1'b1;
		run(0);
		pol <= 1'b1;
		run(2);
		`CHK(icmp_type, SIFWD_ICMP_PARAM)
		bad <= 1'b0;
		pol <= 1'b0;
	endtask

	task automatic t_opts;
		opts <= 1'b1;
		run(0);
		opt_ok <= 1'b1;
		run(1);
		opts <= 1'b0;
		mtu_small <= 1'b1;
		run(0);
		mtu_small <= 1'b0;
		hit <= 1'b0;
		run(0);
		hit <= 1'b1;
	endtask

	task automatic t_ipx;
		is_ipx <= 1'b1;
		hops <= 8'h0F;
		hop_ext <= 8'h10;
		for (int i = 0; i < 3; i++)
		begin
			encap <= sifwd_encap_t'(i);
			stall <= i == 1;
			ce_gap <= i == 1;
			run(1);
		end
		stall <= 1'b0;
		ce_gap <= 1'b0;
		hops <= 8'h10;
		run(0);
		pol <= 1'b1;
		run(2);
		pol <= 1'b0;
		hop_ext <= 8'hFF;
		hops <= 8'hFE;
		run(1);
		net0 <= 1'b1;
		run(0);
		net0 <= 1'b0;
	endtask

	task automatic t_len;
		encap <= SIFWD_ENC_LLC;
		len <= 16'hFFF8;
		run(0);
		len <= 16'hFFF7;
		run(1);
		encap <= SIFWD_ENC_TAG;
		len <= 16'hFFF4;
		run(0);
		len <= 16'hFFF3;
		run(1);
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_ip_sc();
		t_ip_ttl();
		t_ip_err();
		t_opts();
		t_ipx();
		t_len();
		complete_run();
	end
endmodule
